// File: common/flrd_pkg.sv
// flrd_pkg: constants, types and address map for the flash read interface
// assumes: used by logic/flrd_top.sv and the test modules, one core clock domain

package flrd_pkg;

  // ********************************************************
  // widths
  // ********************************************************
  localparam int unsigned ADDR_W  = 32;
  localparam int unsigned LINE_W  = 128;
  localparam int unsigned DW_W    = 64;
  localparam int unsigned WAIT_W  = 3;
  localparam int unsigned SECT_W  = 4;
  localparam int unsigned REG_AW  = 4;
  localparam int unsigned RDATA_W = 32;

  // ********************************************************
  // array map
  // ********************************************************
  localparam logic [31:0] MAIN_BASE  = 32'h0800_0000;
  localparam logic [31:0] MAIN_LAST  = 32'h080F_FFFF;
  localparam logic [31:0] SECT4_BASE = 32'h0801_0000;
  localparam logic [31:0] SECT5_BASE = 32'h0802_0000;
  localparam logic [31:0] SECT11_BASE = 32'h080E_0000;
  localparam logic [31:0] SYS_BASE   = 32'h1FFF_0000;
  localparam logic [31:0] SYS_LAST   = 32'h1FFF_77FF;
  localparam logic [31:0] OTP_BASE   = 32'h1FFF_7800;
  localparam logic [31:0] OTP_LAST   = 32'h1FFF_7A0F;
  localparam logic [31:0] OTP_LOCK   = 32'h1FFF_7A00;
  localparam logic [31:0] OPT_BASE   = 32'h1FFF_C000;
  localparam logic [31:0] OPT_LAST   = 32'h1FFF_C00F;
  localparam int unsigned SMALL_SH   = 14;
  localparam int unsigned BIG_SH     = 17;
  localparam logic [3:0]  SECT_FOUR  = 4'h4;
  localparam logic [3:0]  SECT_FIVE  = 4'h5;
  localparam logic [3:0]  SECT_LASTN = 4'hB;
  localparam logic [3:0]  OTP_LOCK_BLOCKS = 4'hF;

  // ********************************************************
  // registers
  // ********************************************************
  localparam logic [REG_AW-1:0] ACR_OFS    = 4'h0;
  localparam logic [REG_AW-1:0] CR_OFS     = 4'h4;
  localparam logic [REG_AW-1:0] SR_OFS     = 4'h8;
  localparam logic [WAIT_W-1:0] WAIT_RST   = 3'h0;
  localparam logic [WAIT_W-1:0] WAIT_MAX   = 3'h7;
  localparam int unsigned CR_START = 0;
  localparam int unsigned CR_MASS  = 1;
  localparam int unsigned CR_SECT  = 2;
  localparam int unsigned CR_SNB   = 4;
  localparam int unsigned SR_BUSY  = 0;
  localparam int unsigned SR_WPERR = 1;
  localparam int unsigned SR_ERR_W = 2;
  localparam logic [3:0] APPLY_DELAY = 4'h2;
  localparam logic [3:0] OP_CYCLES   = 4'hF;

  // ********************************************************
  // types
  // ********************************************************
  typedef enum logic [2:0] {
    RG_NONE = 3'b000,
    RG_MAIN = 3'b001,
    RG_SYS  = 3'b010,
    RG_OTP  = 3'b011,
    RG_OPT  = 3'b100
  } flrd_region_t;

  typedef enum logic [1:0] {
    PS_BYTE = 2'b00,
    PS_HALF = 2'b01,
    PS_WORD = 2'b10,
    PS_DBL  = 2'b11
  } flrd_psize_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b10,
    ST_OP   = 2'b11
  } flrd_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              req;
  } flrd_rd_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DW_W-1:0]   data;
    flrd_psize_t       size;
    logic              req;
  } flrd_pg_req_t;

  typedef struct packed {
    logic [LINE_W-1:0] line;
    flrd_region_t      region;
    logic [SECT_W-1:0] sector;
    logic              valid;
  } flrd_rd_rsp_t;

endpackage

// File: logic/flrd_top.sv
// flrd_top: flash array read sequencer with wait states, map decode and op guard
// assumes: requester and array on clk_i; array answers its line combinationally
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns

// Notes on behaviour
// - twelve sectors: 4x16K, 1x64K, 7x128K
// - sector zero at base, eleven at top
// - every read returns full 128-bit line
// - program byte, half, word, double word
// - erase one sector or whole main
// - otp 512 bytes plus 16 lock bytes
// - boot area refuses program and erase
// - option bytes decoded as own window
// - read takes wait count plus two cycles
// - wait count resets to zero
// - register reads back count in use
module flrd_top
  import flrd_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                reset_n_i,
  input  wire flrd_rd_req_t        rd_req_i,
  input  wire flrd_pg_req_t        pg_req_i,
  input  wire logic [LINE_W-1:0]   array_line_i,
  input  wire logic [REG_AW-1:0]   reg_addr_i,
  input  wire logic [RDATA_W-1:0]  reg_wdata_i,
  input  wire logic                reg_we_i,
  input  wire logic                reg_re_i,
  output flrd_rd_rsp_t             rd_rsp_o,
  output logic                     rd_stall_o,
  output logic [ADDR_W-1:0]        array_addr_o,
  output logic                     array_pg_o,
  output logic [DW_W-1:0]          array_pg_data_o,
  output logic [7:0]               array_pg_mask_o,
  output logic                     array_erase_o,
  output logic                     array_mass_o,
  output logic [SECT_W-1:0]        array_sector_o,
  output logic [RDATA_W-1:0]       reg_rdata_o
);

  // ********************************************************
  // decode functions
  // ********************************************************
  function automatic flrd_region_t region_of(input logic [ADDR_W-1:0] a);
    if (a >= MAIN_BASE && a <= MAIN_LAST) begin
      region_of = RG_MAIN;
    end else if (a >= SYS_BASE && a <= SYS_LAST) begin
      region_of = RG_SYS;
    end else if (a >= OTP_BASE && a <= OTP_LAST) begin
      region_of = RG_OTP;
    end else if (a >= OPT_BASE && a <= OPT_LAST) begin
      region_of = RG_OPT;
    end else begin
      region_of = RG_NONE;
    end
  endfunction

  function automatic logic [SECT_W-1:0] sector_of(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - MAIN_BASE;
    if (a < SECT4_BASE) begin
      sector_of = SECT_W'(off >> SMALL_SH);
    end else if (a < SECT5_BASE) begin
      sector_of = SECT_FOUR;
    end else begin
      sector_of = SECT_W'((off >> BIG_SH) + 32'(SECT_FOUR));
    end
  endfunction

  function automatic logic [7:0] mask_of(input flrd_psize_t s);
    unique case (s)
      PS_BYTE: mask_of = 8'h01;
      PS_HALF: mask_of = 8'h03;
      PS_WORD: mask_of = 8'h0F;
      PS_DBL:  mask_of = 8'hFF;
    endcase
  endfunction

  // ********************************************************
  // wait-state registers
  // ********************************************************
  logic [WAIT_W-1:0] read_wait_cycles_q;
  logic [WAIT_W-1:0] wait_used_q;
  logic [3:0]        apply_cnt_q;
  logic [SECT_W-1:0] cr_sector_q;
  logic              wp_err_q;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      read_wait_cycles_q <= WAIT_RST;
    end else if (reg_we_i && reg_addr_i == ACR_OFS) begin
      read_wait_cycles_q <= reg_wdata_i[WAIT_W-1:0];
    end
  end

  // new count applied a few cycles later, only between accesses
  flrd_state_t state_q;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wait_used_q <= WAIT_RST;
      apply_cnt_q <= '0;
    end else if (reg_we_i && reg_addr_i == ACR_OFS) begin
      apply_cnt_q <= APPLY_DELAY;
    end else if (apply_cnt_q != '0) begin
      apply_cnt_q <= apply_cnt_q - 4'h1;
    end else if (state_q == ST_IDLE) begin
      wait_used_q <= read_wait_cycles_q;
    end
  end

  // ********************************************************
  // register read port
  // ********************************************************
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= '0;
    end else if (reg_re_i) begin
      unique case (reg_addr_i)
        ACR_OFS: reg_rdata_o <= RDATA_W'(wait_used_q);
        CR_OFS:  reg_rdata_o <= RDATA_W'({cr_sector_q, 4'h0});
        SR_OFS:  reg_rdata_o <= RDATA_W'({wp_err_q, state_q == ST_OP});
        default: reg_rdata_o <= '0;
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end

  // ********************************************************
  // erase command register
  // ********************************************************
  logic erase_go;
  logic mass_go;
  assign erase_go = reg_we_i && reg_addr_i == CR_OFS && reg_wdata_i[CR_START]
                    && reg_wdata_i[CR_SECT];
  assign mass_go  = reg_we_i && reg_addr_i == CR_OFS && reg_wdata_i[CR_START]
                    && reg_wdata_i[CR_MASS];

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cr_sector_q <= '0;
    end else if (reg_we_i && reg_addr_i == CR_OFS) begin
      cr_sector_q <= reg_wdata_i[CR_SNB +: SECT_W];
    end
  end

  // ********************************************************
  // access sequencer
  // ********************************************************
  flrd_region_t      rd_region;
  flrd_region_t      pg_region;
  logic [SECT_W-1:0] erase_sect;
  logic              pg_ok;
  logic              erase_ok;
  logic [WAIT_W-1:0] wait_cnt_q;
  logic [3:0]        op_cnt_q;
  logic [ADDR_W-1:0] addr_q;
  flrd_region_t      region_q;

  assign rd_region  = region_of(rd_req_i.addr);
  assign pg_region  = region_of(pg_req_i.addr);
  assign erase_sect = erase_go ? reg_wdata_i[CR_SNB +: SECT_W] : cr_sector_q;
  // boot and option windows never written here
  assign pg_ok    = pg_region == RG_MAIN || pg_region == RG_OTP;
  assign erase_ok = mass_go || erase_sect <= SECT_LASTN;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_q    <= ST_IDLE;
      wait_cnt_q <= '0;
      op_cnt_q   <= '0;
      addr_q     <= '0;
      region_q   <= RG_NONE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if ((erase_go || mass_go) && erase_ok) begin
            state_q  <= ST_OP;
            op_cnt_q <= OP_CYCLES;
          end else if (pg_req_i.req && pg_ok) begin
            state_q  <= ST_OP;
            op_cnt_q <= OP_CYCLES;
          // a request still held while its line goes out is not taken twice
          end else if (rd_req_i.req && !rd_rsp_o.valid) begin
            addr_q     <= rd_req_i.addr;
            region_q   <= rd_region;
            wait_cnt_q <= wait_used_q;
            state_q    <= (wait_used_q == '0) ? ST_DONE : ST_WAIT;
          end
        end
        ST_WAIT: begin
          wait_cnt_q <= wait_cnt_q - 3'h1;
          if (wait_cnt_q == 3'h1) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        ST_OP: begin
          op_cnt_q <= op_cnt_q - 4'h1;
          if (op_cnt_q == 4'h1) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ********************************************************
  // protection error flag
  // ********************************************************
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wp_err_q <= 1'b0;
    end else if (state_q == ST_IDLE && pg_req_i.req && !pg_ok) begin
      wp_err_q <= 1'b1;
    end else if (reg_we_i && reg_addr_i == SR_OFS && reg_wdata_i[SR_WPERR]) begin
      wp_err_q <= 1'b0;
    end
  end

  // ********************************************************
  // outputs to requester and array
  // ********************************************************
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rd_rsp_o   <= '0;
      rd_stall_o <= 1'b0;
    end else begin
      rd_rsp_o.valid <= state_q == ST_DONE;
      rd_rsp_o.line  <= array_line_i;
      rd_rsp_o.region <= region_q;
      rd_rsp_o.sector <= (region_q == RG_MAIN) ? sector_of(addr_q) : '0;
      rd_stall_o     <= state_q == ST_WAIT || state_q == ST_OP
                        || (state_q == ST_IDLE && rd_req_i.req && !rd_rsp_o.valid);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      array_addr_o    <= '0;
      array_pg_o      <= 1'b0;
      array_pg_data_o <= '0;
      array_pg_mask_o <= '0;
      array_erase_o   <= 1'b0;
      array_mass_o    <= 1'b0;
      array_sector_o  <= '0;
    end else begin
      array_pg_o    <= state_q == ST_IDLE && !(erase_go || mass_go)
                       && pg_req_i.req && pg_ok;
      array_erase_o <= state_q == ST_IDLE && erase_go && !mass_go && erase_ok;
      array_mass_o  <= state_q == ST_IDLE && mass_go;
      array_sector_o <= erase_sect;
      array_pg_data_o <= pg_req_i.data;
      array_pg_mask_o <= mask_of(pg_req_i.size);
      if (state_q == ST_IDLE) begin
        array_addr_o <= pg_req_i.req ? pg_req_i.addr : rd_req_i.addr;
      end
    end
  end

endmodule

// File: test/flrd_top_monitor.sv
// flrd_top_monitor: port assertions for the flash read sequencer
// assumes: bound to flrd_top, single clock, sync active-low reset
`timescale 1ns/1ns
module flrd_top_monitor
  import flrd_pkg::*;
(
  input wire logic               clk_i,
  input wire logic               reset_n_i,
  input wire flrd_rd_req_t       rd_req_i,
  input wire flrd_pg_req_t       pg_req_i,
  input wire logic [REG_AW-1:0]  reg_addr_i,
  input wire logic               reg_re_i,
  input wire flrd_rd_rsp_t       rd_rsp_o,
  input wire logic               rd_stall_o,
  input wire logic               array_pg_o,
  input wire logic               array_erase_o,
  input wire logic               array_mass_o,
  input wire logic [RDATA_W-1:0] reg_rdata_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [ADDR_W-1:0] a;
  logic [SECT_W-1:0] sx;
  assign a  = rd_req_i.addr;
  assign sx = (a < SECT4_BASE) ? 4'(a[15:14]) :
              (a < SECT5_BASE) ? 4'h4 : 4'(a[19:17]) + 4'h4;
  // ********************************************************
  // assertions
  // ********************************************************
  chk_quiet_reset: assert property (disable iff (1'b0)
    !reset_n_i |=> !rd_rsp_o.valid && !rd_stall_o) else $error("outputs active in reset");
  chk_read_hold: assert property ($rose(rd_req_i.req) |=> rd_stall_o && !rd_rsp_o.valid)
    else $error("line returned too early");
  chk_valid_pulse: assert property (rd_rsp_o.valid |=> !rd_rsp_o.valid)
    else $error("valid longer than one cycle");
  chk_main_sector: assert property (rd_rsp_o.valid && a >= MAIN_BASE && a <= MAIN_LAST
    |-> rd_rsp_o.region == RG_MAIN && rd_rsp_o.sector == sx) else $error("sector decode");
  chk_otp_window: assert property (rd_rsp_o.valid && a >= OTP_BASE && a <= OTP_LAST
    |-> rd_rsp_o.region == RG_OTP) else $error("otp decode");
  chk_opt_window: assert property (rd_rsp_o.valid && a >= OPT_BASE && a <= OPT_LAST
    |-> rd_rsp_o.region == RG_OPT) else $error("option decode");
  chk_boot_guard: assert property (pg_req_i.req && pg_req_i.addr >= SYS_BASE
    && pg_req_i.addr <= SYS_LAST |=> !array_pg_o [*3]) else $error("boot area programmed");
  chk_rdata_idle: assert property (!$past(reg_re_i) |-> reg_rdata_o == '0)
    else $error("read data outside read cycle");
  chk_wait_field: assert property (reg_re_i && reg_addr_i == ACR_OFS
    |=> reg_rdata_o[RDATA_W-1:WAIT_W] == '0) else $error("wait field too wide");
  chk_erase_excl: assert property (array_mass_o |-> !array_erase_o)
    else $error("mass and sector erase together");
endmodule

bind flrd_top flrd_top_monitor u_mon (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .rd_req_i(rd_req_i), .pg_req_i(pg_req_i),
  .reg_addr_i(reg_addr_i), .reg_re_i(reg_re_i), .rd_rsp_o(rd_rsp_o),
  .rd_stall_o(rd_stall_o), .array_pg_o(array_pg_o), .array_erase_o(array_erase_o),
  .array_mass_o(array_mass_o), .reg_rdata_o(reg_rdata_o));

// File: test/flrd_array_model.sv
// flrd_array_model: flash array returning a line per address
// assumes: combinational answer to the address presented
`timescale 1ns/1ns
module flrd_array_model
  import flrd_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr_i,
  output logic      [LINE_W-1:0] line_o
);
  // four distinct words so any narrowed line shows
  assign line_o = {~addr_i, addr_i ^ 32'h5A5A_A5A5, addr_i + 32'h1, addr_i};
endmodule

// File: test/tb_flash_array_read_read_wait_cycles.sv
// tb_flash_array_read_read_wait_cycles: directed bench for flrd_top
// assumes: array model on the array port, 50 MHz clock
`timescale 1ns/1ns
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin n_fail++; \
  $display("mismatch %0t %s", $time, m); end end
module tb_flash_array_read_read_wait_cycles;
  import flrd_pkg::*;
  logic               clk_i, reset_n_i, we, re, stall, pg, er, ms;
  flrd_rd_req_t       rq;
  flrd_pg_req_t       pq;
  flrd_rd_rsp_t       rsp;
  logic [LINE_W-1:0]  line;
  logic [REG_AW-1:0]  ra;
  logic [RDATA_W-1:0] wd, rd;
  logic [ADDR_W-1:0]  aa;
  logic [DW_W-1:0]    pd;
  logic [7:0]         pm;
  logic [SECT_W-1:0]  sec, sc_seen;
  logic [7:0]         pm_seen;
  logic [DW_W-1:0]    pd_seen;
  logic [ADDR_W-1:0]  aa_seen;
  int                 n_fail, check_count;
  flrd_top u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .rd_req_i(rq), .pg_req_i(pq),
    .array_line_i(line), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_we_i(we), .reg_re_i(re),
    .rd_rsp_o(rsp), .rd_stall_o(stall), .array_addr_o(aa), .array_pg_o(pg),
    .array_pg_data_o(pd), .array_pg_mask_o(pm), .array_erase_o(er), .array_mass_o(ms),
    .array_sector_o(sec), .reg_rdata_o(rd));
  flrd_array_model u_arr (.addr_i(aa), .line_o(line));
  function automatic logic [LINE_W-1:0] expl(input logic [ADDR_W-1:0] a);
    return {~a, a ^ 32'h5A5A_A5A5, a + 32'h1, a};
  endfunction
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_fail, check_count);
    if (n_fail == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [REG_AW-1:0] a, input logic [RDATA_W-1:0] d);
    @(posedge clk_i); ra <= a; wd <= d; we <= 1'b1;
    @(posedge clk_i); we <= 1'b0;
  endtask
  task automatic rdr(input logic [REG_AW-1:0] a, output logic [RDATA_W-1:0] d);
    @(posedge clk_i); ra <= a; re <= 1'b1;
    @(posedge clk_i); re <= 1'b0;
    #1 d = rd;
  endtask
  // watch one pulse output for four edges, starting at the current edge
  task automatic poll(input int sel, output bit hit);
    hit = 0;
    repeat (4) begin
      #1 if ((sel == 0 ? pg : sel == 1 ? ms : er) === 1'b1) begin
        hit = 1;
        sc_seen = sec;
        pm_seen = pm;
        pd_seen = pd;
        aa_seen = aa;
      end
      @(posedge clk_i); pq.req <= 1'b0;
    end
  endtask
  task automatic idle();
    int n;
    n = 0;
    while (stall !== 1'b0 && n < 60) begin @(posedge clk_i); #1 n++; end
    `CHK(stall, 1'b0, "still busy")
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input int w, input flrd_region_t rg,
                        input logic [SECT_W-1:0] sc);
    int n;
    n = 0;
    @(posedge clk_i); rq <= '{addr: a, req: 1'b1};
    do begin @(posedge clk_i); #1 n++; end while (rsp.valid !== 1'b1 && n < 20);
    `CHK(n, w + 2, "read read_wait_cycles")
    `CHK(rsp.line, expl(a), "line content")
    `CHK(rsp.region, rg, "region")
    `CHK(rsp.sector, sc, "sector")
    @(posedge clk_i);
    rq.req <= 1'b0;
  endtask
  // ********************************************************
  // scenarios
  // ********************************************************
  task automatic t_reset();
    logic [RDATA_W-1:0] d;
    rdr(ACR_OFS, d);
    `CHK(d, 32'h0000_0000, "wait count after reset")
    rdr(4'hC, d);
    `CHK(d, 32'h0000_0000, "unmapped read")
  endtask
  task automatic t_map();
    logic [ADDR_W-1:0] ta[11] = '{32'h0800_0000, 32'h0800_C000, 32'h0801_0000, 32'h0802_0000,
      32'h080E_0000, 32'h080F_FFF0, 32'h1FFF_0000, 32'h1FFF_7800, 32'h1FFF_7A00,
      32'h1FFF_C000, 32'h1FFF_7A10};
    flrd_region_t tr[11] = '{RG_MAIN, RG_MAIN, RG_MAIN, RG_MAIN, RG_MAIN, RG_MAIN, RG_SYS,
      RG_OTP, RG_OTP, RG_OPT, RG_NONE};
    logic [SECT_W-1:0] ts[11] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'hB, 4'hB, 4'h0, 4'h0, 4'h0,
      4'h0, 4'h0};
    foreach (ta[i]) rd_chk(ta[i], 0, tr[i], ts[i]);
  endtask
  task automatic t_wait();
    logic [RDATA_W-1:0] d;
    int ws[4] = '{7, 3, 1, 0};
    int k;
    foreach (ws[i]) begin
      wr(ACR_OFS, RDATA_W'(ws[i]));
      k = 0;
      do begin rdr(ACR_OFS, d); k++; end while (d !== RDATA_W'(ws[i]) && k < 10);
      `CHK(d, RDATA_W'(ws[i]), "wait count read back")
      rd_chk(SECT11_BASE, ws[i], RG_MAIN, 4'hB);
    end
  endtask
  task automatic t_prog();
    logic [RDATA_W-1:0] d;
    bit hit;
    logic [7:0] mk[4] = '{8'h01, 8'h03, 8'h0F, 8'hFF};
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_i); pq <= '{addr: MAIN_BASE + 32'(s * 16), data: 64'h1122_3344_5566_7788,
        size: flrd_psize_t'(s), req: 1'b1};
      @(posedge clk_i); pq.req <= 1'b0;
      poll(0, hit);
      `CHK(hit, 1'b1, "program start")
      `CHK(pm_seen, mk[s], "byte mask")
      `CHK(pd_seen, 64'h1122_3344_5566_7788, "program data")
      `CHK(aa_seen, MAIN_BASE + 32'(s * 16), "program address")
      idle();
    end
    @(posedge clk_i); pq <= '{addr: SYS_BASE, data: 64'h0, size: PS_WORD, req: 1'b1};
    @(posedge clk_i); pq.req <= 1'b0;
    poll(0, hit);
    `CHK(hit, 1'b0, "boot area programmed")
    rdr(SR_OFS, d);
    `CHK(d[SR_WPERR], 1'b1, "protection error flag")
    wr(SR_OFS, 32'h0000_0002);
    rdr(SR_OFS, d);
    `CHK(d[SR_WPERR], 1'b0, "protection error clear")
  endtask
  task automatic t_erase();
    bit hit;
    wr(CR_OFS, 32'h0000_0003);
    poll(1, hit);
    `CHK(hit, 1'b1, "mass erase")
    idle();
    wr(CR_OFS, 32'h0000_0055);
    poll(2, hit);
    `CHK(hit, 1'b1, "sector erase")
    `CHK(sc_seen, 4'h5, "erase sector")
    idle();
  endtask
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    #200000;
    n_fail++;
    close_out();
  end
  initial begin
    n_fail = 0; check_count = 0; reset_n_i = 1'b0; we = 1'b0; re = 1'b0;
    ra = '0; wd = '0; rq = '0; pq = '0; sc_seen = '0;
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_map();
    t_wait();
    t_prog();
    t_erase();
    close_out();
  end
endmodule
